/* File: rxopt_pkg.sv */
// Package with the register map, field positions and reset values of the receive options bank.
// Contract
// - Normal-mode space is decoded only when address bit 7 is low.
// - Writes to unused bits change nothing; their read value is undefined.
// - Every writable configuration bit reads back its last written value.
// - Device reset clears every writable normal-mode bit to zero.
// - Writes to read-only bit positions do not alter device operation.
// - Unframed bit disables the frame aligner; data passes unaligned.
// - Alarm integrator keeps detecting red and AIS while unframed.
// - Bypass bit routes store input data and clock straight to outputs.
// - Slip bit substitutes transmit formatter clock for backplane receive clock.
// - Slip clock substitution applies only while bypass is also set.
// - PCM select bit picks undecoded or decoded recovered PCM output.
// - Superframe select pulses on first framing bit of each superframe.
// - With superframe select clear, pulse on every framing bit.
// - Alternate bit suppresses every second frame pulse.
// - Count select picks alignment-change or out-of-frame events for the monitor.
// - All seven control bits clear on reset; bit 7 is unused.
// - Registers are reached over an 8-bit parallel host bus.
package rxopt_pkg;
  localparam logic [7:0] RXOPT_RECEIVE_OPTIONS_ADDR = 8'h00;
  localparam int         RXOPT_TEST_SPACE_BIT       = 7;
  localparam int         RXOPT_UNFRAMED_BIT         = 6;
  localparam int         RXOPT_BYPASS_BIT           = 5;
  localparam int         RXOPT_SLIP_BIT             = 4;
  localparam int         RXOPT_PCM_BIT              = 3;
  localparam int         RXOPT_SFP_BIT              = 2;
  localparam int         RXOPT_ALT_BIT              = 1;
  localparam int         RXOPT_COUNT_BIT            = 0;
  localparam logic [6:0] RXOPT_CTRL_RESET           = 7'h00;
  localparam logic [7:0] RXOPT_UNMAPPED_READ        = 8'h00;
endpackage

/* File: rxopt_ctl_if.sv */
// Interface carrying the decoded control bits from the register bank to the datapath selects.
`timescale 1ns/10ps
interface rxopt_ctl_if;
  logic unframed_mode;
  logic elastic_store_bypass;
  logic slip_measure_select;
  logic undecoded_pcm_select;
  logic superframe_pulse_select;
  logic alternate_frame_pulse;
  logic count_alignment_change;
  modport bank (output unframed_mode, elastic_store_bypass, slip_measure_select,
                output undecoded_pcm_select, superframe_pulse_select,
                output alternate_frame_pulse, count_alignment_change);
  modport path (input unframed_mode, elastic_store_bypass, slip_measure_select,
                input undecoded_pcm_select, superframe_pulse_select,
                input alternate_frame_pulse, count_alignment_change);
endinterface

/* File: rxopt_frame_pulse.sv */
// Frame pulse selector with alternate-pulse suppression.
`timescale 1ns/10ps
module rxopt_frame_pulse
  import rxopt_pkg::*;
(
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst_n,
  // Controls.
  rxopt_ctl_if.path ctl,
  // Framing strobes.
  input  wire logic framing_bit_strobe,
  input  wire logic superframe_start_strobe,
  // Output.
  output logic      frame_pulse_out
);
  logic cand;
  logic toggle_r;
  logic toggle_nxt;
  logic pulse_r;
  logic pulse_nxt;

  // Pick the candidate pulse source, then drop every second one when asked.
  always_comb
  begin
    cand       = ctl.superframe_pulse_select ? superframe_start_strobe
                                             : framing_bit_strobe;
    toggle_nxt = toggle_r;
    pulse_nxt  = 1'b0;
    if (cand)
    begin
      toggle_nxt = ~toggle_r;
      pulse_nxt  = ~(ctl.alternate_frame_pulse & toggle_r);
    end
  end

  // Register the pulse and the suppression phase.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      toggle_r <= 1'b0;
      pulse_r  <= 1'b0;
    end
    else
    begin
      toggle_r <= toggle_nxt;
      pulse_r  <= pulse_nxt;
    end
  end

  assign frame_pulse_out = pulse_r;

  // Alternate mode never passes two candidates in a row.
  alt_suppress_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ctl.alternate_frame_pulse && pulse_nxt) |-> !toggle_r)
    else $error("alternate pulse not suppressed");
endmodule

/* File: rxopt_bank.sv */
// Receive options register bank on the 8-bit host bus, with the selects it steers.
`timescale 1ns/10ps
module rxopt_bank
  import rxopt_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Host bus.
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  output logic      [7:0] host_rdata,
  // Receive datapath inputs.
  input  wire logic       recovered_data,
  input  wire logic       recovered_clock,
  input  wire logic       elastic_store_data,
  input  wire logic       elastic_store_clock,
  input  wire logic       transmit_formatter_clock,
  input  wire logic       backplane_receive_clock,
  input  wire logic       raw_pcm_in,
  input  wire logic       decoded_pcm_in,
  input  wire logic       framing_bit_strobe,
  input  wire logic       superframe_start_strobe,
  input  wire logic       alignment_change_event,
  input  wire logic       out_of_frame_event,
  // Datapath outputs.
  output logic            frame_aligner_enable,
  output logic            alarm_integrator_enable,
  output logic            store_data_out,
  output logic            store_clock_out,
  output logic            store_system_clock,
  output logic            pcm_out,
  output logic            frame_pulse_out,
  output logic            monitor_count_event
);
  logic       rst_s1_r;
  logic       rst_n_r;
  logic [6:0] ctrl_r;
  logic [6:0] ctrl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       normal_space;
  logic       hit;

  rxopt_ctl_if ctl ();

  // Release reset through two flip-flops.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Decode the address; test space is never claimed.
  assign normal_space = ~host_addr[RXOPT_TEST_SPACE_BIT];
  assign hit          = normal_space && (host_addr == RXOPT_RECEIVE_OPTIONS_ADDR);

  // Next register and read data values.
  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    rdata_nxt = rdata_r;
    if (host_wr && hit)
    begin
      ctrl_nxt = host_wdata[6:0];
    end
    if (host_rd)
    begin
      rdata_nxt = hit ? {1'b0, ctrl_r} : RXOPT_UNMAPPED_READ;
    end
  end

  // Register the control bits and read data.
  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ctrl_r  <= RXOPT_CTRL_RESET;
      rdata_r <= 8'h00;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign host_rdata = rdata_r;

  // Break the control register into named bits.
  assign ctl.unframed_mode           = ctrl_r[RXOPT_UNFRAMED_BIT];
  assign ctl.elastic_store_bypass    = ctrl_r[RXOPT_BYPASS_BIT];
  assign ctl.slip_measure_select     = ctrl_r[RXOPT_SLIP_BIT];
  assign ctl.undecoded_pcm_select    = ctrl_r[RXOPT_PCM_BIT];
  assign ctl.superframe_pulse_select = ctrl_r[RXOPT_SFP_BIT];
  assign ctl.alternate_frame_pulse   = ctrl_r[RXOPT_ALT_BIT];
  assign ctl.count_alignment_change  = ctrl_r[RXOPT_COUNT_BIT];

  // Datapath selects steered by the control bits.
  assign frame_aligner_enable    = ~ctl.unframed_mode;
  assign alarm_integrator_enable = 1'b1;
  assign store_data_out  = ctl.elastic_store_bypass ? recovered_data : elastic_store_data;
  assign store_clock_out = ctl.elastic_store_bypass ? recovered_clock
                                                    : elastic_store_clock;
  assign store_system_clock = (ctl.elastic_store_bypass && ctl.slip_measure_select)
                              ? transmit_formatter_clock : backplane_receive_clock;
  assign pcm_out = ctl.undecoded_pcm_select ? raw_pcm_in : decoded_pcm_in;
  assign monitor_count_event = ctl.count_alignment_change ? alignment_change_event
                                                          : out_of_frame_event;

  // Frame pulse generation.
  rxopt_frame_pulse u_fp
  (
    .mclk                   (mclk),
    .rst_n                  (rst_n_r),
    .ctl                    (ctl.path),
    .framing_bit_strobe     (framing_bit_strobe),
    .superframe_start_strobe(superframe_start_strobe),
    .frame_pulse_out        (frame_pulse_out)
  );

  // A write lands in the register on the next edge.
  write_lands_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    (host_wr && hit) |=> (ctrl_r == $past(host_wdata[6:0])))
    else $error("write not stored");
  // Test space writes never touch the register.
  test_space_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    (host_wr && host_addr[7]) |=> $stable(ctrl_r))
    else $error("test space write changed register");
  // Bit 7 always reads zero.
  unused_zero_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    !host_rdata[7])
    else $error("unused bit read as one");
  // Slip clock only with bypass.
  slip_gate_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    !ctl.elastic_store_bypass |-> (store_system_clock == backplane_receive_clock))
    else $error("slip clock without bypass");
  // Aligner follows unframed bit.
  aligner_off_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    frame_aligner_enable != ctl.unframed_mode)
    else $error("aligner enable wrong");
  // Monitor source follows count select.
  count_src_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    monitor_count_event == (ctl.count_alignment_change ? alignment_change_event
                                                       : out_of_frame_event))
    else $error("monitor source wrong");
  // Read returns the register one cycle later.
  read_back_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    (host_rd && hit && !host_wr) |=> (host_rdata == {1'b0, $past(ctrl_r)}))
    else $error("read back wrong");
  // After reset the bank is clear.
  reset_clear_a: assert property (@(posedge mclk)
    $rose(rst_n_r) |-> (ctrl_r == 7'h00))
    else $error("reset value wrong");
endmodule

/* File: tb_top.sv */
// Self-checking testbench for the receive options register bank.
`timescale 1ns/10ps
module tb_top;
  import rxopt_pkg::*;
  logic       mclk;
  logic       reset_n;
  logic [7:0] host_addr;
  logic [7:0] host_wdata;
  logic       host_wr;
  logic       host_rd;
  logic [7:0] host_rdata;
  logic [9:0] din;
  logic       fstb;
  logic       sstb;
  logic [7:0] dout;
  logic       rd_pend;
  logic [7:0] fp_cnt;
  logic [7:0] rq[$];
  logic [31:0] seed;
  int         num_errors;
  int         checks;
  rxopt_bank dut_u (.mclk(mclk), .reset_n(reset_n), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
    .recovered_data(din[0]), .recovered_clock(din[1]), .elastic_store_data(din[2]),
    .elastic_store_clock(din[3]), .transmit_formatter_clock(din[4]),
    .backplane_receive_clock(din[5]), .raw_pcm_in(din[6]), .decoded_pcm_in(din[7]),
    .framing_bit_strobe(fstb), .superframe_start_strobe(sstb),
    .alignment_change_event(din[8]), .out_of_frame_event(din[9]),
    .frame_aligner_enable(dout[0]), .alarm_integrator_enable(dout[1]),
    .store_data_out(dout[2]), .store_clock_out(dout[3]), .store_system_clock(dout[4]),
    .pcm_out(dout[5]), .frame_pulse_out(dout[6]), .monitor_count_event(dout[7]));
  // Clock generation at 50 MHz.
  initial
  begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    host_addr = a;
    host_wdata = d;
    host_wr = 1;
    @(posedge mclk);
    #1;
    host_wr = 0;
  endtask
  // The read expectation is noted here and compared by the read monitor.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    #1;
    host_addr = a;
    host_rd = 1;
    rq.push_back(e);
    @(posedge mclk);
    #1;
    host_rd = 0;
  endtask
  task automatic pulse_run(input logic sf, input logic alt, input logic [7:0] e);
    wr(RXOPT_RECEIVE_OPTIONS_ADDR, {5'h00, sf, alt, 1'b0});
    fp_cnt = 0;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge mclk);
      #1;
      fstb = 1;
      sstb = (k % 2 == 0);
      @(posedge mclk);
      #1;
      fstb = 0;
      sstb = 0;
      repeat (2) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    check("frame_pulse_count", e, fp_cnt);
  endtask
  // Read monitor: takes the oldest note once the registered read data has landed.
  always @(posedge mclk) rd_pend <= host_rd;
  always @(negedge mclk)
    if (rd_pend)
      check("host_rdata", rq.pop_front(), host_rdata);
  // Frame pulses are counted one per high cycle.
  always @(posedge mclk) if (dout[6] === 1'b1) fp_cnt <= fp_cnt + 8'h01;
  // Watchdog that cuts a hang short.
  initial
  begin
    #200000;
    num_errors++;
    final_report();
  end
  // Main sequence.
  initial
  begin
    logic [7:0] v;
    seed = 36;
    {host_addr, host_wdata, host_wr, host_rd, din, fstb, sstb, fp_cnt} = '0;
    reset_n = 0;
    repeat (20) @(posedge mclk);
    #1;
    reset_n = 1;
    repeat (4) @(posedge mclk);
    rd(RXOPT_RECEIVE_OPTIONS_ADDR, 8'h00);
    for (int i = 0; i < 14; i++)
    begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h30 : (i == 2) ? 8'h10 : 8'(rnd());
      wr(RXOPT_RECEIVE_OPTIONS_ADDR, v);
      din = 10'(rnd());
      #2;
      check("aligner_en", {7'h00, ~v[6]}, {7'h00, dout[0]});
      check("alarm_en", 8'h01, {7'h00, dout[1]});
      check("store_data", {7'h00, v[5] ? din[0] : din[2]}, {7'h00, dout[2]});
      check("store_clock", {7'h00, v[5] ? din[1] : din[3]}, {7'h00, dout[3]});
      check("sys_clock", {7'h00, (v[5] & v[4]) ? din[4] : din[5]}, {7'h00, dout[4]});
      check("pcm_out", {7'h00, v[3] ? din[6] : din[7]}, {7'h00, dout[5]});
      check("count_event", {7'h00, v[0] ? din[8] : din[9]}, {7'h00, dout[7]});
      rd(RXOPT_RECEIVE_OPTIONS_ADDR, {1'b0, v[6:0]});
    end
    // Writes outside the register, test space included, are ignored and read as zero.
    wr(8'h80, 8'h00);
    wr(8'h01, 8'h00);
    rd(8'h80, RXOPT_UNMAPPED_READ);
    rd(RXOPT_RECEIVE_OPTIONS_ADDR, {1'b0, v[6:0]});
    pulse_run(1'b0, 1'b0, 8'h08);
    pulse_run(1'b0, 1'b1, 8'h04);
    pulse_run(1'b1, 1'b0, 8'h04);
    pulse_run(1'b1, 1'b1, 8'h02);
    repeat (3) @(posedge mclk);
    final_report();
  end
endmodule
